// ---- hdl/flc_pkg.sv ----
package flc_pkg;

    // Register word indices; byte address is four times the index.
    localparam logic [7:0] IDX_POWER_MGMT_TWO = 8'h03;
    localparam logic [7:0] IDX_LOOP_CTRL_ONE = 8'h3c;
    localparam logic [7:0] IDX_LOOP_FRACTION = 8'h3d;
    localparam logic [7:0] IDX_LOOP_INTEGER = 8'h3e;
    localparam logic [7:0] IDX_LOOP_GAIN_OUTDIV = 8'h3f;
    localparam logic [7:0] IDX_LOOP_STATUS = 8'h40;

    // Field positions.
    localparam int POS_DIGITAL_ENABLE = 15;
    localparam int POS_LOW_REF_LOCK = 12;
    localparam int POS_REF_SOURCE = 10;
    localparam int POS_FRAC_MODE = 9;
    localparam int POS_ANALOG_ENABLE = 8;
    localparam int POS_CTRL_RATE = 5;
    localparam int POS_VCO_RATIO = 0;
    localparam int POS_TRACK_GAIN = 3;
    localparam int POS_OUT_DIV = 0;

    // Values after reset.
    localparam logic RST_LOW_REF_LOCK = 1'b1;
    localparam logic [1:0] RST_REF_SOURCE = 2'h0;
    localparam logic [2:0] RST_CTRL_RATE = 3'h0;
    localparam logic [4:0] RST_VCO_RATIO = 5'h08;
    localparam logic [15:0] RST_FRACTION = 16'h0000;
    localparam logic [9:0] RST_INTEGER = 10'h000;
    localparam logic [3:0] RST_TRACK_GAIN = 4'h0;
    localparam logic [2:0] RST_OUT_DIV = 3'h3;

    // Lock counts in reference clock periods.
    localparam logic [9:0] LOCK_COUNT_HIGH_REF = 10'd509;
    localparam logic [9:0] LOCK_COUNT_LOW_REF = 10'd49;

    // Largest legal codes.
    localparam logic [2:0] MAX_CTRL_RATE = 3'h5;
    localparam logic [3:0] MAX_TRACK_GAIN = 4'h8;
    localparam logic [2:0] MAX_OUT_DIV = 3'h4;

    typedef enum logic [1:0] {
        FLC_SRC_MCLK = 2'h0,
        FLC_SRC_DAC_FRAME = 2'h1,
        FLC_SRC_ADC_FRAME = 2'h2,
        FLC_SRC_GPIO_SIX = 2'h3
    } flc_src_t;

    typedef struct packed {
        logic digital_enable;
        logic analog_enable;
        logic low_ref_lock_select;
        flc_src_t ref_source;
        logic fractional_mode;
        logic [2:0] control_block_rate;
        logic [4:0] vco_ratio_divider;
        logic [15:0] fraction_multiplier;
        logic [9:0] integer_multiplier;
        logic [3:0] tracking_gain;
        logic [2:0] output_divider;
    } flc_cfg_t;

    typedef struct packed {
        logic [15:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } flc_avm_req_t;

endpackage

// ---- hdl/flc_top.sv ----
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module flc_top (
    input wire logic clk, // 250 MHz system clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [15:0] avs_address, // Avalon word... byte address
    input wire logic avs_read, // Avalon read strobe
    input wire logic avs_write, // Avalon write strobe
    input wire logic [31:0] avs_writedata, // Avalon write data
    input wire logic [3:0] avs_byteenable, // Avalon byte enables
    output logic [31:0] avs_readdata, // Avalon read data
    output logic avs_waitrequest, // Avalon wait request
    output logic [1:0] avs_response, // Avalon response, 2 = slave error
    input wire logic ref_mclk_pin, // Master clock pin reference
    input wire logic ref_dac_frame, // DAC frame clock reference
    input wire logic ref_adc_frame, // ADC frame clock reference
    input wire logic ref_gpio_six, // General purpose pin six reference
    output flc_pkg::flc_cfg_t loop_cfg, // Settings for the analogue loop
    output logic [31:0] loop_multiplier, // N.K times ratio, 16.16 fixed
    output logic [8:0] loop_error_gain, // Tracking gain multiplier
    output logic [5:0] ctrl_rate_divisor, // Control-block clock divisor
    output logic [5:0] out_divisor, // Output divisor, 0 when reserved
    output logic loop_locked, // Lock declared
    output logic system_clock_valid // Output clock usable
);

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, answer on the second edge.

    logic ack_q;
    logic [15:0] power_q;
    logic [15:0] ctrl_one_q;
    logic [15:0] fraction_q;
    logic [15:0] integer_q;
    logic [15:0] gain_outdiv_q;
    logic [7:0] word_idx;
    logic req;
    logic hit;
    logic [15:0] rd_word;
    logic [15:0] wmask;
    logic locked_q;
    logic [9:0] lock_cnt_q;

    // Gathering the request in one word keeps the decode below in step.
    flc_pkg::flc_avm_req_t bus_req;
    logic [15:0] wr_word;

    always_comb begin
        bus_req.address = avs_address;
        bus_req.read = avs_read;
        bus_req.write = avs_write;
        bus_req.writedata = avs_writedata;
        bus_req.byteenable = avs_byteenable;
    end

    assign word_idx = bus_req.address[9:2];
    assign req = bus_req.read | bus_req.write;
    assign wr_word = bus_req.writedata[15:0];
    assign avs_waitrequest = req & ~ack_q;
    assign wmask = {{8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};

    always_comb begin
        hit = 1'b1;
        rd_word = 16'h0000;
        unique case (word_idx)
            flc_pkg::IDX_POWER_MGMT_TWO: rd_word = power_q;
            flc_pkg::IDX_LOOP_CTRL_ONE: rd_word = ctrl_one_q;
            flc_pkg::IDX_LOOP_FRACTION: rd_word = fraction_q;
            flc_pkg::IDX_LOOP_INTEGER: rd_word = integer_q;
            flc_pkg::IDX_LOOP_GAIN_OUTDIV: rd_word = gain_outdiv_q;
            flc_pkg::IDX_LOOP_STATUS: rd_word = {5'h00, locked_q, lock_cnt_q};
            default: hit = 1'b0;
        endcase
        if (avs_address[15:10] != 6'h00) begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (req & ~ack_q) begin
            avs_readdata <= {16'h0000, (avs_read & hit) ? rd_word : 16'h0000};
            avs_response <= hit ? 2'h0 : 2'h2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file. Only the documented bits are kept; others read zero.

    logic wr_now;
    assign wr_now = avs_write & ~ack_q & hit;

    // The power register keeps only the digital enable; the other bits of
    // that word belong to blocks outside this one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_q <= 16'h0000;
        end else if (wr_now && word_idx == flc_pkg::IDX_POWER_MGMT_TWO) begin
            power_q <= ((power_q & ~wmask) | (wr_word & wmask))
                & 16'h8000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_one_q <= {3'h0, flc_pkg::RST_LOW_REF_LOCK,
                flc_pkg::RST_REF_SOURCE, 1'b0, 1'b0,
                flc_pkg::RST_CTRL_RATE, flc_pkg::RST_VCO_RATIO};
        end else if (wr_now && word_idx == flc_pkg::IDX_LOOP_CTRL_ONE) begin
            ctrl_one_q <= ((ctrl_one_q & ~wmask) | (wr_word & wmask))
                & 16'h1fff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fraction_q <= flc_pkg::RST_FRACTION;
        end else if (wr_now && word_idx == flc_pkg::IDX_LOOP_FRACTION) begin
            fraction_q <= (fraction_q & ~wmask) | (wr_word & wmask);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            integer_q <= {6'h00, flc_pkg::RST_INTEGER};
        end else if (wr_now && word_idx == flc_pkg::IDX_LOOP_INTEGER) begin
            integer_q <= ((integer_q & ~wmask) | (wr_word & wmask))
                & 16'h03ff;
        end
    end

    // Reserved divider codes are stored as written; the decode below
    // turns them into a zero divisor so that no clock is offered.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_outdiv_q <= {9'h000, flc_pkg::RST_TRACK_GAIN,
                flc_pkg::RST_OUT_DIV};
        end else if (wr_now && word_idx == flc_pkg::IDX_LOOP_GAIN_OUTDIV) begin
            gain_outdiv_q <= ((gain_outdiv_q & ~wmask) | (wr_word & wmask))
                & 16'h007f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings.

    flc_pkg::flc_cfg_t cfg;
    always_comb begin
        cfg.digital_enable = power_q[flc_pkg::POS_DIGITAL_ENABLE];
        cfg.analog_enable = ctrl_one_q[flc_pkg::POS_ANALOG_ENABLE];
        cfg.low_ref_lock_select = ctrl_one_q[flc_pkg::POS_LOW_REF_LOCK];
        cfg.ref_source = flc_pkg::flc_src_t'(
            ctrl_one_q[flc_pkg::POS_REF_SOURCE +: 2]);
        cfg.fractional_mode = ctrl_one_q[flc_pkg::POS_FRAC_MODE];
        cfg.control_block_rate = ctrl_one_q[flc_pkg::POS_CTRL_RATE +: 3];
        cfg.vco_ratio_divider = ctrl_one_q[flc_pkg::POS_VCO_RATIO +: 5];
        cfg.fraction_multiplier = fraction_q;
        cfg.integer_multiplier = integer_q[9:0];
        cfg.tracking_gain = gain_outdiv_q[flc_pkg::POS_TRACK_GAIN +: 4];
        cfg.output_divider = gain_outdiv_q[flc_pkg::POS_OUT_DIV +: 3];
    end

    // Fractional bits are ignored in integer mode; MSB of K is one half.
    logic [25:0] nk_fixed;
    assign nk_fixed = {cfg.integer_multiplier,
        cfg.fractional_mode ? cfg.fraction_multiplier : 16'h0000};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_cfg <= '0;
            loop_multiplier <= 32'h0000_0000;
        end else begin
            loop_cfg <= cfg;
            loop_multiplier <= 32'(nk_fixed * cfg.vco_ratio_divider);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_error_gain <= 9'h001;
        end else begin
            loop_error_gain <= (cfg.tracking_gain <= flc_pkg::MAX_TRACK_GAIN)
                ? 9'(9'h001 << cfg.tracking_gain) : 9'h000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_rate_divisor <= 6'h01;
        end else begin
            ctrl_rate_divisor <=
                (cfg.control_block_rate <= flc_pkg::MAX_CTRL_RATE)
                ? 6'(6'h01 << cfg.control_block_rate) : 6'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_divisor <= 6'h10;
        end else begin
            out_divisor <= (cfg.output_divider <= flc_pkg::MAX_OUT_DIV)
                ? 6'(6'h02 << cfg.output_divider) : 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference selection and lock counting. Every reference is an
    // asynchronous pin, so each passes two flops; edges are then detected
    // on the second stage only. References must be slower than clk / 4.

    logic [3:0] sync2_q;
    logic sel_prev_q;
    logic sel_ref;

    flc_sync2 #(
        .WIDTH(4)
    ) ref_sync (
        .clk(clk),
        .rst(rst),
        .d({ref_gpio_six, ref_adc_frame, ref_dac_frame, ref_mclk_pin}),
        .q(sync2_q)
    );

    always_comb begin
        unique case (cfg.ref_source)
            flc_pkg::FLC_SRC_MCLK: sel_ref = sync2_q[0];
            flc_pkg::FLC_SRC_DAC_FRAME: sel_ref = sync2_q[1];
            flc_pkg::FLC_SRC_ADC_FRAME: sel_ref = sync2_q[2];
            flc_pkg::FLC_SRC_GPIO_SIX: sel_ref = sync2_q[3];
        endcase
    end

    logic ref_rise;
    logic [9:0] lock_target;
    logic loop_run;
    logic [9:0] cnt_next;
    assign ref_rise = sel_ref & ~sel_prev_q;
    assign cnt_next = 10'(lock_cnt_q + 10'h001);
    assign lock_target = cfg.low_ref_lock_select
        ? flc_pkg::LOCK_COUNT_LOW_REF : flc_pkg::LOCK_COUNT_HIGH_REF;
    // The digital loop runs only with both halves on; a digital enable set
    // ahead of the analogue one simply waits for it.
    assign loop_run = cfg.digital_enable & cfg.analog_enable;

    // The previous level is tracked even while disabled, so enabling the
    // loop during a high reference phase does not count a false edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_ref;
        end
    end

    // A disabled loop forgets all progress, so a new reference starts from a
    // full count only if the loop is disabled around the change of source.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_q <= 10'h000;
        end else if (!loop_run) begin
            lock_cnt_q <= 10'h000;
        end else if (ref_rise && !locked_q) begin
            lock_cnt_q <= cnt_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            locked_q <= 1'b0;
        end else if (!loop_run) begin
            locked_q <= 1'b0;
        end else if (ref_rise && !locked_q && cnt_next >= lock_target) begin
            locked_q <= 1'b1;
        end
    end

    assign loop_locked = locked_q;
    assign system_clock_valid = locked_q & (out_divisor != 6'h00);

endmodule

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for pins that arrive from outside the clock domain.

module flc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] d, // Asynchronous inputs
    output logic [WIDTH-1:0] q // Synchronised outputs
);

    logic [WIDTH-1:0] meta_q;

    // Only the second stage may be read; the first can be metastable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/flc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module flc_assertions (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic [15:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic avs_waitrequest, // wait
    input wire logic [1:0] avs_response, // response
    input wire flc_pkg::flc_cfg_t loop_cfg, // settings
    input wire logic [8:0] loop_error_gain, // gain
    input wire logic [5:0] ctrl_rate_divisor, // rate
    input wire logic [5:0] out_divisor, // divider
    input wire logic loop_locked, // lock
    input wire logic system_clock_valid // valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence read_done;
        avs_read && !avs_waitrequest;
    endsequence
    ////////////////////////////////////////
    wait_cycle_a: assert property (req_wait |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    idle_nowait_a: assert property (!(avs_read || avs_write)
        |-> !avs_waitrequest) else $error("wait raised while idle");
    unmapped_resp_a: assert property (read_done |-> avs_response ==
        (avs_address[15:10] == 6'h0 && avs_address[9:2] inside
        {8'h03, [8'h3c:8'h40]} ? 2'h0 : 2'h2)) else $error("bad response");
    clock_valid_a: assert property (system_clock_valid ==
        (loop_locked && out_divisor != 6'h0)) else $error("valid wrong");
    digital_off_a: assert property (!loop_cfg.digital_enable[*2]
        |-> !loop_locked) else $error("locked while disabled");
    lock_enable_a: assert property ($rose(loop_locked) |->
        loop_cfg.digital_enable && loop_cfg.analog_enable)
        else $error("lock without both enables");
    // The first edge after reset still shows reset-time outputs, so skip it.
    out_div_a: assert property (!$past(rst) &&
        $stable(loop_cfg.output_divider) |-> out_divisor ==
        (loop_cfg.output_divider > 3'h4 ? 6'h0 :
        6'h2 << loop_cfg.output_divider)) else $error("divisor wrong");
    track_gain_a: assert property (!$past(rst) &&
        $stable(loop_cfg.tracking_gain) |-> loop_error_gain ==
        (loop_cfg.tracking_gain > 4'h8 ? 9'h0 :
        9'h1 << loop_cfg.tracking_gain)) else $error("gain wrong");
    ctrl_rate_a: assert property (!$past(rst) &&
        $stable(loop_cfg.control_block_rate) |-> ctrl_rate_divisor ==
        (loop_cfg.control_block_rate > 3'h5 ? 6'h0 :
        6'h1 << loop_cfg.control_block_rate)) else $error("rate wrong");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
        miscompares++; \
        $display("unexpected at %0t: %h %h", $time, (a), (b)); \
    end \
end
module testbench;
    localparam logic [7:0] PW = flc_pkg::IDX_POWER_MGMT_TWO;
    localparam logic [7:0] C1 = flc_pkg::IDX_LOOP_CTRL_ONE;
    localparam logic [7:0] KF = flc_pkg::IDX_LOOP_FRACTION;
    localparam logic [7:0] NI = flc_pkg::IDX_LOOP_INTEGER;
    localparam logic [7:0] G4 = flc_pkg::IDX_LOOP_GAIN_OUTDIV;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [15:0] avs_address = 16'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, loop_multiplier, q;
    logic [3:0] refs = 4'h0;
    logic [1:0] avs_response, r;
    logic [8:0] loop_error_gain;
    logic [5:0] ctrl_rate_divisor, out_divisor;
    logic avs_waitrequest, loop_locked, system_clock_valid;
    flc_pkg::flc_cfg_t loop_cfg;
    int miscompares = 0, cmp_count = 0;
    flc_top dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'h3), .avs_readdata,
        .avs_waitrequest, .avs_response, .ref_mclk_pin(refs[0]),
        .ref_dac_frame(refs[1]), .ref_adc_frame(refs[2]),
        .ref_gpio_six(refs[3]), .loop_cfg, .loop_multiplier,
        .loop_error_gain, .ctrl_rate_divisor, .out_divisor, .loop_locked,
        .system_clock_valid);
    ////////////////////////////////////////
    task automatic end_sim();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [15:0] d);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        avs_address <= {6'h0, i, 2'h0};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0, d};
        // Sample the settled answer midway, it stands at the next rise.
        do begin
            @(negedge clk);
            done = (avs_waitrequest === 1'b0);
            q = avs_readdata;
            r = avs_response;
            n++;
            @(posedge clk);
        end while (!done && n < 20);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!done) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic rdc(input logic [7:0] i, input logic [15:0] e);
        bus(1'b0, i, 16'h0);
        `CHK(q, {16'h0, e})
    endtask
    task automatic pulses(input logic [1:0] s, input int n);
        repeat (n) begin
            refs[s] <= 1'b1;
            repeat (4) @(posedge clk);
            refs[s] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rdc(PW, 16'h0000);
        rdc(C1, 16'h1008);
        rdc(KF, 16'h0000);
        rdc(NI, 16'h0000);
        rdc(G4, 16'h0003);
        bus(1'b0, 8'h80, 16'h0);
        `CHK(r, 2'h2)
        `CHK(q, 32'h0)
    endtask
    task automatic t_mult();
        bus(1'b1, KF, 16'haaab);
        bus(1'b1, NI, 16'hffff);
        rdc(NI, 16'h03ff);
        bus(1'b1, NI, 16'h0002);
        bus(1'b1, C1, 16'h1203);
        repeat (3) @(posedge clk);
        `CHK(loop_multiplier, 32'h0002aaab * 32'h3)
        bus(1'b1, C1, 16'h1003);
        repeat (3) @(posedge clk);
        `CHK(loop_multiplier, 32'h00020000 * 32'h3)
        rdc(KF, 16'haaab);
    endtask
    task automatic t_codes();
        logic [2:0] c;
        for (int i = 0; i < 10; i++) begin
            c = i[2:0];
            bus(1'b1, G4, {9'h0, i[3:0], c});
            bus(1'b1, C1, {8'h10, c, 5'h08});
            repeat (3) @(posedge clk);
            `CHK(loop_error_gain, i > 8 ? 9'h0 : 9'h1 << i)
            `CHK(out_divisor, c > 4 ? 6'h0 : 6'h2 << c)
            `CHK(ctrl_rate_divisor, c > 5 ? 6'h0 : 6'h1 << c)
        end
    endtask
    // Only the selected reference may advance the lock count.
    task automatic t_lock(input logic [1:0] s, input logic sel);
        bus(1'b1, PW, 16'h0000);
        bus(1'b1, G4, 16'h0002);
        bus(1'b1, C1, {3'h0, sel, s, 5'h18, sel ? 5'h08 : 5'h01});
        bus(1'b1, PW, 16'h8000);
        pulses(s + 2'h1, 60);
        `CHK(loop_locked, 1'b0)
        pulses(s, sel ? 48 : 508);
        repeat (6) @(posedge clk);
        `CHK(loop_locked, 1'b0)
        pulses(s, 1);
        repeat (6) @(posedge clk);
        `CHK(loop_locked, 1'b1)
        `CHK(system_clock_valid, 1'b1)
        bus(1'b1, PW, 16'h0000);
        repeat (4) @(posedge clk);
        `CHK(loop_locked, 1'b0)
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mult();
        t_codes();
        for (int s = 0; s < 4; s++) begin
            t_lock(s[1:0], 1'b1);
        end
        t_lock(2'h0, 1'b0);
        end_sim();
    end
endmodule
bind flc_top flc_assertions chk (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_waitrequest, .avs_response, .loop_cfg,
    .loop_error_gain, .ctrl_rate_divisor, .out_divisor, .loop_locked,
    .system_clock_valid);
`default_nettype wire
